// ==== shared/pin_change_pkg.sv ====
// Purpose: Constants and types for the pin change edge detector
// Assumes: APB slave, 32-bit data, one word per register
// Notes: Unimplemented bit positions are masked off in every register
//
// Notes on behaviour
// - A rising edge on a pin whose rise enable is 1 sets that pin's change flag.
// - A falling edge on a pin whose fall enable is 1 sets that pin's change flag.
// - An edge in a direction not enabled for a pin leaves its flag unchanged.
// - The port C flag register holds eight per-pin flags in bits 7 to 0, all eight implemented.
// - Flags are read and written by software and set by hardware, and a set beats a coinciding write.
// - All change flags reset to 0 on every reset.
// - Bit positions with no pin read as 0 and ignore writes.
// - Any per-pin flag set by an enabled edge also sets the summary change flag.
// - A pin with both enables 0 never sets a flag.
package pin_change_pkg;

    localparam int unsigned NUM_PORTS = 3;

    // Register byte offsets
    localparam logic [7:0] OFF_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PORTA_RISE_ENABLES = 8'h04;
    localparam logic [7:0] OFF_PORTA_FALL_ENABLES = 8'h08;
    localparam logic [7:0] OFF_PORTA_CHANGE_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_PORTB_RISE_ENABLES = 8'h10;
    localparam logic [7:0] OFF_PORTB_FALL_ENABLES = 8'h14;
    localparam logic [7:0] OFF_PORTB_CHANGE_FLAGS = 8'h18;
    localparam logic [7:0] OFF_PORTC_RISE_ENABLES = 8'h1c;
    localparam logic [7:0] OFF_PORTC_FALL_ENABLES = 8'h20;
    localparam logic [7:0] OFF_PORTC_CHANGE_FLAGS = 8'h24;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;

    // Implemented pin masks per port
    localparam logic [7:0] PORTA_PIN_MASK = 8'h3f;
    localparam logic [7:0] PORTB_PIN_MASK = 8'hf0;
    localparam logic [7:0] PORTC_PIN_MASK = 8'hff;

    // Interrupt control fields
    localparam int unsigned BIT_SUMMARY_FLAG = 0;
    localparam int unsigned BIT_SUMMARY_ENABLE = 3;
    localparam int unsigned BIT_PERIPHERAL_EN = 6;
    localparam int unsigned BIT_GLOBAL_EN = 7;
    localparam logic [7:0] INTCTL_WRITE_MASK = 8'hc8;

    // Irq status bits: one per port
    localparam logic [2:0] IRQ_STATUS_MASK = 3'h7;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] RESET_IRQ = 3'h0;

    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] flags;
    } port_regs_s;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [31:0] wdata;
        logic access;
    } bus_req_s;

endpackage

// ==== src/pin_change_edge_detect.sv ====
// Purpose: Per-pin rising/falling edge detection with flags and interrupt
// Assumes: Pins are asynchronous and pass two flip-flops first
// Notes: APB slave, zero wait states, unmapped reads give zero and pslverr
`timescale 1ns/1ps
`default_nettype none

module pin_change_edge_detect (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins
    input wire logic [7:0] porta_pin,
    input wire logic [7:0] portb_pin,
    input wire logic [7:0] portc_pin,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= pin_change_pkg::OFF_IRQ_MASK) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [7:0] port_mask(input int unsigned p);
        case (p)
            0: port_mask = pin_change_pkg::PORTA_PIN_MASK;
            1: port_mask = pin_change_pkg::PORTB_PIN_MASK;
            default: port_mask = pin_change_pkg::PORTC_PIN_MASK;
        endcase
    endfunction

    function automatic logic [7:0] port_base(input int unsigned p);
        case (p)
            0: port_base = pin_change_pkg::OFF_PORTA_RISE_ENABLES;
            1: port_base = pin_change_pkg::OFF_PORTB_RISE_ENABLES;
            default: port_base = pin_change_pkg::OFF_PORTC_RISE_ENABLES;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------
    pin_change_pkg::bus_req_s req;
    logic wr_en;
    logic rd_en;
    logic lane0;

    always_comb begin
        req.addr = paddr[7:0];
        req.write = pwrite;
        req.wdata = pwdata;
        req.access = psel && penable && (paddr[31:8] == 24'h000000);
    end

    assign wr_en = req.access && req.write;
    assign rd_en = req.access && !req.write;
    assign lane0 = pstrb[0];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [23:0] pins_in;
    logic [23:0] sync1_q;
    logic [23:0] sync2_q;
    logic [23:0] prev_q;

    assign pins_in = {portc_pin, portb_pin, porta_pin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 24'h000000;
            sync2_q <= 24'h000000;
            prev_q <= 24'h000000;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ------------------------------------------------------------
    // Per-port enables, edge detect and flags
    // ------------------------------------------------------------
    pin_change_pkg::port_regs_s regs_q [pin_change_pkg::NUM_PORTS];
    logic [7:0] hit [pin_change_pkg::NUM_PORTS];
    logic [2:0] port_hit;
    logic [2:0] port_any_flag;

    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_port
            localparam logic [7:0] MASK = port_mask(gp);
            localparam logic [7:0] BASE = port_base(gp);
            logic [7:0] cur;
            logic [7:0] old;
            logic [7:0] rose;
            logic [7:0] fell;
            logic [7:0] flags_d;

            assign cur = sync2_q[gp*8 +: 8];
            assign old = prev_q[gp*8 +: 8];
            assign rose = cur & ~old;
            assign fell = ~cur & old;
            // Only enabled directions count; both enables 0 means no detection
            assign hit[gp] = ((rose & regs_q[gp].rise)
                              | (fell & regs_q[gp].fall)) & MASK;
            assign port_hit[gp] = |hit[gp];
            assign port_any_flag[gp] = |regs_q[gp].flags;

            always_comb begin
                flags_d = regs_q[gp].flags;
                if (wr_en && lane0 && req.addr == BASE + 8'h08) begin
                    flags_d = req.wdata[7:0] & MASK;
                end
                flags_d = flags_d | hit[gp];
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs_q[gp].rise <= pin_change_pkg::RESET_BYTE;
                    regs_q[gp].fall <= pin_change_pkg::RESET_BYTE;
                    regs_q[gp].flags <= pin_change_pkg::RESET_BYTE;
                end else begin
                    if (wr_en && lane0 && req.addr == BASE) begin
                        regs_q[gp].rise <= req.wdata[7:0] & MASK;
                    end
                    if (wr_en && lane0 && req.addr == BASE + 8'h04) begin
                        regs_q[gp].fall <= req.wdata[7:0] & MASK;
                    end
                    regs_q[gp].flags <= flags_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt control and summary
    // ------------------------------------------------------------
    logic summary_flag;
    logic [7:0] intctl_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic [2:0] status_rd_clr;

    // Summary follows the OR of flags; a fresh hit shows at once
    assign summary_flag = (|port_any_flag) || (|port_hit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intctl_q <= pin_change_pkg::RESET_BYTE;
        end else if (wr_en && lane0 && req.addr == pin_change_pkg::OFF_INTERRUPT_CONTROL) begin
            intctl_q <= req.wdata[7:0] & pin_change_pkg::INTCTL_WRITE_MASK;
        end
    end

    // Sticky per-port events, cleared by a read; a new event beats the clear
    // Clear only the bits that the read returned, so an event landing in the
    // setup cycle stays pending for the next read
    assign status_rd_clr = (rd_en && req.addr == pin_change_pkg::OFF_IRQ_STATUS) ?
                           prdata[2:0] : pin_change_pkg::RESET_IRQ;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= pin_change_pkg::RESET_IRQ;
        end else begin
            irq_status_q <= (irq_status_q & ~status_rd_clr) | port_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= pin_change_pkg::RESET_IRQ;
        end else if (wr_en && lane0 && req.addr == pin_change_pkg::OFF_IRQ_MASK) begin
            irq_mask_q <= req.wdata[2:0] & pin_change_pkg::IRQ_STATUS_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (summary_flag && intctl_q[pin_change_pkg::BIT_SUMMARY_ENABLE])
                   || (|(irq_status_q & irq_mask_q));
        end
    end

    // ------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    logic [7:0] intctl_view;
    logic addr_ok;

    // Refused addresses answer with an error and zero data
    assign addr_ok = mapped(paddr[7:0]) && (paddr[31:8] == 24'h000000);

    always_comb begin
        intctl_view = intctl_q;
        intctl_view[pin_change_pkg::BIT_SUMMARY_FLAG] = |port_any_flag;
    end

    always_comb begin
        rd_byte = 8'h00;
        case (req.addr)
            pin_change_pkg::OFF_INTERRUPT_CONTROL: rd_byte = intctl_view;
            pin_change_pkg::OFF_PORTA_RISE_ENABLES: rd_byte = regs_q[0].rise;
            pin_change_pkg::OFF_PORTA_FALL_ENABLES: rd_byte = regs_q[0].fall;
            pin_change_pkg::OFF_PORTA_CHANGE_FLAGS: rd_byte = regs_q[0].flags;
            pin_change_pkg::OFF_PORTB_RISE_ENABLES: rd_byte = regs_q[1].rise;
            pin_change_pkg::OFF_PORTB_FALL_ENABLES: rd_byte = regs_q[1].fall;
            pin_change_pkg::OFF_PORTB_CHANGE_FLAGS: rd_byte = regs_q[1].flags;
            pin_change_pkg::OFF_PORTC_RISE_ENABLES: rd_byte = regs_q[2].rise;
            pin_change_pkg::OFF_PORTC_FALL_ENABLES: rd_byte = regs_q[2].fall;
            pin_change_pkg::OFF_PORTC_CHANGE_FLAGS: rd_byte = regs_q[2].flags;
            pin_change_pkg::OFF_IRQ_STATUS: rd_byte = {5'h00, irq_status_q};
            pin_change_pkg::OFF_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
            default: rd_byte = 8'h00;
        endcase
    end

    // Zero-wait answer in the access cycle, registered from the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite && addr_ok) ?
                      {24'h000000, rd_byte} : 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ==== verification/pin_change_checker_props.sv ====
// Purpose: Port-level checks of the pin change edge detector
// Assumes: Zero wait state APB slave, registered irq
// Notes: Bound to every instance of the design
`timescale 1ns/1ps
`default_nettype none

module pin_change_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONLY_ACCESS: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 32'h2c |=> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    AST_PORTB_LOW: assert property (pready && !pwrite && paddr == 32'h18 |-> prdata[3:0] == 4'h0)
        else $error("absent pins read nonzero");
    AST_IRQ_RESET: assert property ($rose(presetn) |-> !irq && !pready)
        else $error("outputs active after reset");

    COV_IRQ: cover property ($rose(irq));
    COV_ERR: cover property (pslverr);
    COV_READ: cover property (pready && !pwrite && prdata != 0);
endmodule

bind pin_change_edge_detect pin_change_checker pin_change_checker_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ==== verification/pin_source_model.sv ====
// Purpose: External pins driving the three ports
// Assumes: Caller is just past a rising clock edge
// Notes: Pins are always driven, never floating
`timescale 1ns/1ps
`default_nettype none

module pin_source_model (
    // Pins
    output logic [7:0] porta_pin,
    output logic [7:0] portb_pin,
    output logic [7:0] portc_pin
);
    initial {porta_pin, portb_pin, portc_pin} = 24'h0;

    task put(input logic [23:0] v);
        {porta_pin, portb_pin, portc_pin} <= v;
    endtask
endmodule
`default_nettype wire

// ==== verification/pin_change_edge_detect_test.sv ====
// Purpose: Self-checking bench with a behavioural register model
// Assumes: Pins settle into flags within five cycles
// Notes: Random enables, flags and pins from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module pin_change_edge_detect_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, irq;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r;
    logic [3:0] pstrb = 4'hf;
    logic slverr = 0;
    logic [7:0] pa, pb, pc;
    int num_errors = 0, total_checks = 0, seed = 39120;
    int rise[3], fall[3], flg[3], pm[3], old[3], nw[3], h, stat, ic, msk;

    pin_change_edge_detect pin_change_edge_detect_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porta_pin(pa), .portb_pin(pb), .portc_pin(pc), .irq(irq));
    pin_source_model pin_source_model_inst (.porta_pin(pa), .portb_pin(pb), .portc_pin(pc));

    initial begin
        forever #5 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        slverr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #500000;
        num_errors++;
        summarize;
    end

    initial begin
        pm = '{int'(pin_change_pkg::PORTA_PIN_MASK), int'(pin_change_pkg::PORTB_PIN_MASK),
            int'(pin_change_pkg::PORTC_PIN_MASK)};
        old = '{0, 0, 0};
        stat = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int a = 0; a <= 32'h2c; a += 4) begin
            apb(0, a, 0);
            chk(r, 0);
        end
        apb(0, 32'h30, 0);
        chk({r[30:0], slverr}, 1);
        for (int it = 0; it < 16; it++) begin
            ic = $random(seed) & 8'hc8;
            msk = $random(seed) & 7;
            apb(1, 0, ic);
            apb(1, 32'h2c, msk);
            apb(0, 32'h28, 0);
            chk(r, stat);
            stat = 0;
            for (int p = 0; p < 3; p++) begin
                rise[p] = $random(seed) & pm[p];
                fall[p] = $random(seed) & pm[p];
                flg[p] = $random(seed) & pm[p];
                apb(1, 4 + 12 * p, rise[p]);
                apb(1, 8 + 12 * p, fall[p]);
                apb(1, 12 + 12 * p, $random(seed) & 8'hff | flg[p]);
                apb(1, 12 + 12 * p, flg[p]);
                apb(0, 12 + 12 * p, 0);
                chk(r, flg[p]);
                nw[p] = $random(seed) & 8'hff;
                h = ((rise[p] & ~old[p] & nw[p]) | (fall[p] & old[p] & ~nw[p])) & pm[p];
                flg[p] |= h;
                if (h != 0) stat |= 1 << p;
                old[p] = nw[p];
            end
            pin_source_model_inst.put({nw[0][7:0], nw[1][7:0], nw[2][7:0]});
            repeat (5) @(posedge pclk);
            for (int p = 0; p < 3; p++) begin
                apb(0, 12 + 12 * p, 0);
                chk(r, flg[p]);
            end
            h = (flg[0] | flg[1] | flg[2]) != 0;
            chk(irq, (h & ic[3]) | ((stat & msk) != 0));
            apb(0, 0, 0);
            chk(r, ic | h);
            apb(0, 32'h28, 0);
            chk(r, stat);
            stat = 0;
        end
        // Clearing write lands on the same edge as a hardware set
        apb(1, 32'h1c, 8'hff);
        apb(1, 32'h20, 8'hff);
        pin_source_model_inst.put({old[0][7:0], old[1][7:0], ~old[2][7:0]});
        @(posedge pclk);
        apb(1, 32'h24, 0);
        apb(0, 32'h24, 0);
        chk(r, 8'hff);
        pstrb <= 4'h0;
        apb(1, 32'h24, 0);
        pstrb <= 4'hf;
        apb(0, 32'h24, 0);
        chk(r, 8'hff);
        apb(1, 32'h24, 0);
        apb(0, 32'h24, 0);
        chk(r, 0);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 32'h24, 0);
        chk(r, 0);
        summarize;
    end
endmodule
`default_nettype wire
